// File: design/osc_ctrl_pkg.sv
// Constants for the main oscillator control and frequency meter block
package osc_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ_MEASURE = 8'h04;
  localparam logic [7:0] OFS_POWER_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h10;
  localparam logic [7:0] OFS_PERIPH_EN = 8'h14;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h18;
  // Field positions
  localparam int OSC_EN_POS = 0;
  localparam int OSC_COUNT_LSB = 8;
  localparam int STARTUP_W = 8;
  localparam int MEAS_DONE_POS = 16;
  localparam int STABLE_POS = 0;
  localparam int CPU_RUN_POS = 1;
  localparam int MODE_LSB = 2;
  localparam int SRC_LSB = 0;
  localparam int USB_DIV2_POS = 4;
  localparam int PROG_SEL_LSB = 8;
  localparam int IDLE_REQ_POS = 0;
  // Slow clock falling edges in one measurement
  localparam logic [4:0] MEAS_SLOW_PERIODS = 5'h10;
  // Timing of the register clock
  localparam int REF_CLK_PERIOD_PS = 25000;
  localparam int REF_CLK_HZ = 1000000000 / (REF_CLK_PERIOD_PS / 1000);
  // Reset values
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [7:0] PROG_SEL_RESET = 8'h00;
  localparam logic [7:0] STARTUP_RESET = 8'h00;

  // System clock source
  typedef enum logic [1:0] {
    SRC_LOW_SPEED = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_PLL = 2'h2
  } clk_src_e;

  // Operating mode as shown to software
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_IDLE = 2'h1,
    MODE_SLOW = 2'h2,
    MODE_STANDBY = 2'h3
  } op_mode_e;

  // Frequency meter sequence, Gray coded along its path
  typedef enum logic [1:0] {
    METER_OFF = 2'b00,
    METER_ARM = 2'b01,
    METER_COUNT = 2'b11,
    METER_DONE = 2'b10
  } meter_state_e;
endpackage

// File: design/main_osc_control.sv
// Main oscillator control, operating modes and main clock frequency meter
// Function
// - After reset the main oscillator is off and the system runs from the slow clock.
// - Clearing the oscillator enable stops it and clears the stable flag.
// - Enable write with count clears stable, loads count, decrements each slow cycle.
// - Startup count field is eight bits wide, about 62 ms at most.
// - Countdown reaching zero sets the oscillator stable flag.
// - Stable flag with its mask bit set raises the interrupt request.
// - Once stable, meter counts main clock cycles after next slow rising edge.
// - Meter stops and sets done at the sixteenth slow falling edge.
// - Frozen meter value is readable as main cycles in fifteen and a half slow periods.
// - Normal mode runs the processor clock and software-enabled peripheral clocks.
// - Idle stops the processor clock until a wake-up request or reset; peripherals keep running.
// - Slow mode turns the PLL off and leaves the oscillator enable as written; it is the reset mode.
// - Standby is slow clock operation with the processor clock stopped.
// - The slow clock never stops and times startup and measurement counters.
// - System bus clock stays on, source selectable from slow, main or PLL.
// - Each peripheral clock is gated independently.
// - An optional divide-by-two is provided on the USB clock path.
// - Four programmable clock outputs each select a generator clock.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module main_osc_control
  import osc_ctrl_pkg::*;
#(
  parameter int NUM_PERIPH = 30,
  parameter int MEAS_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock pins and wake-up
  input wire logic low_speed_clk,
  input wire logic main_clk,
  input wire logic wake_req,
  // Clock controls
  output logic main_osc_en,
  output logic pll_power_en,
  output logic [1:0] sys_clk_source,
  output logic cpu_clk_en,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic usb_div2_en,
  output logic [7:0] prog_clk_sel,
  output logic [1:0] op_mode,
  output logic irq_req
);

  // Pin synchronisers: three flops, level moves once the last two agree
  logic [2:0] slow_sync, main_sync, wake_sync;
  logic slow_lvl, main_lvl, wake_lvl;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_sync <= 3'h0;
      main_sync <= 3'h0;
      wake_sync <= 3'h0;
      slow_lvl <= 1'b0;
      main_lvl <= 1'b0;
      wake_lvl <= 1'b0;
    end else begin
      slow_sync <= {slow_sync[1:0], low_speed_clk};
      main_sync <= {main_sync[1:0], main_clk};
      wake_sync <= {wake_sync[1:0], wake_req};
      if (slow_sync[1] == slow_sync[2]) slow_lvl <= slow_sync[2];
      if (main_sync[1] == main_sync[2]) main_lvl <= main_sync[2];
      if (wake_sync[1] == wake_sync[2]) wake_lvl <= wake_sync[2];
    end
  end

  // Slow clock edges time every counter here, it being the one clock that never stops
  logic slow_prev, main_prev;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_prev <= 1'b0;
      main_prev <= 1'b0;
    end else begin
      slow_prev <= slow_lvl;
      main_prev <= main_lvl;
    end
  end
  wire slow_rise = slow_lvl && !slow_prev;
  wire slow_fall = !slow_lvl && slow_prev;
  wire main_rise = main_lvl && !main_prev;

  // AHB-Lite address phase capture; reads take one wait state
  logic wr_pend, rd_pend;
  logic [7:0] dp_addr;
  wire addr_ok = hsel && htrans[1] && hready;
  wire acc_wr = wr_pend;
  wire acc_rd = rd_pend;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      rd_pend <= addr_ok && !hwrite;
      if (addr_ok) dp_addr <= haddr[7:0];
      hreadyout <= !(addr_ok && !hwrite);
    end
  end
  wire wr_osc = acc_wr && (dp_addr == OFS_OSC_CTRL);
  wire wr_mask = acc_wr && (dp_addr == OFS_IRQ_MASK);
  wire wr_clk = acc_wr && (dp_addr == OFS_CLK_CTRL);
  wire wr_per = acc_wr && (dp_addr == OFS_PERIPH_EN);
  wire wr_cpu = acc_wr && (dp_addr == OFS_CPU_CTRL);
  wire wr_osc_on = wr_osc && hwdata[OSC_EN_POS];
  wire wr_osc_off = wr_osc && !hwdata[OSC_EN_POS];
  wire [STARTUP_W-1:0] wr_count = hwdata[OSC_COUNT_LSB +: STARTUP_W];

  // Oscillator enable and startup countdown
  logic [STARTUP_W-1:0] osc_startup_count, startup_left;
  logic counting, osc_stable_flag;
  wire count_zero = counting && slow_rise && (startup_left == '0);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_en <= 1'b0;
      osc_startup_count <= STARTUP_RESET;
      startup_left <= STARTUP_RESET;
      counting <= 1'b0;
      osc_stable_flag <= 1'b0;
    end else if (wr_osc_off) begin
      main_osc_en <= 1'b0;
      osc_startup_count <= wr_count;
      counting <= 1'b0;
      osc_stable_flag <= 1'b0;
    end else if (wr_osc_on) begin
      main_osc_en <= 1'b1;
      osc_startup_count <= wr_count;
      startup_left <= wr_count;
      counting <= 1'b1;
      osc_stable_flag <= 1'b0;
    end else if (count_zero) begin
      counting <= 1'b0;
      osc_stable_flag <= 1'b1;
    end else if (counting && slow_rise) begin
      startup_left <= startup_left - 1'b1;
    end
  end

  // Frequency meter; a lost stable flag discards the measurement
  meter_state_e meter_state, next_meter_state;
  logic [4:0] fall_cnt;
  logic [MEAS_W-1:0] measured_cycle_count;
  logic freq_measure_done;
  wire last_fall = slow_fall && (fall_cnt == MEAS_SLOW_PERIODS - 5'h01);
  always_comb begin
    next_meter_state = meter_state;
    case (meter_state)
      METER_OFF: if (osc_stable_flag) next_meter_state = METER_ARM;
      METER_ARM: if (slow_rise) next_meter_state = METER_COUNT;
      METER_COUNT: if (last_fall) next_meter_state = METER_DONE;
      default: next_meter_state = METER_DONE;
    endcase
    if (!osc_stable_flag) next_meter_state = METER_OFF;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meter_state <= METER_OFF;
      fall_cnt <= 5'h00;
      measured_cycle_count <= '0;
      freq_measure_done <= 1'b0;
    end else begin
      meter_state <= next_meter_state;
      freq_measure_done <= (next_meter_state == METER_DONE);
      if (meter_state == METER_ARM) begin
        fall_cnt <= 5'h00;
        measured_cycle_count <= '0;
      end else if (meter_state == METER_COUNT) begin
        if (slow_fall) fall_cnt <= fall_cnt + 5'h01;
        if (main_rise) measured_cycle_count <= measured_cycle_count + 1'b1;
      end
    end
  end

  // Clock selection, gating and processor idle
  logic irq_mask;
  logic cpu_run;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= 1'b0;
      sys_clk_source <= SRC_RESET;
      usb_div2_en <= 1'b0;
      prog_clk_sel <= PROG_SEL_RESET;
      periph_clk_en <= '0;
      cpu_run <= 1'b1;
    end else begin
      if (wr_mask) irq_mask <= hwdata[STABLE_POS];
      if (wr_clk) begin
        sys_clk_source <= hwdata[SRC_LSB +: 2];
        usb_div2_en <= hwdata[USB_DIV2_POS];
        prog_clk_sel <= hwdata[PROG_SEL_LSB +: 8];
      end
      if (wr_per) periph_clk_en <= hwdata[NUM_PERIPH-1:0];
      // Wake-up wins over an idle request in the same cycle
      if (wake_lvl) cpu_run <= 1'b1;
      else if (wr_cpu && hwdata[IDLE_REQ_POS]) cpu_run <= 1'b0;
    end
  end

  wire src_slow = (sys_clk_source == SRC_LOW_SPEED);
  wire [1:0] next_op_mode = src_slow ? (cpu_run ? MODE_SLOW : MODE_STANDBY)
                                     : (cpu_run ? MODE_NORMAL : MODE_IDLE);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en <= 1'b1;
      pll_power_en <= 1'b0;
      op_mode <= MODE_SLOW;
      irq_req <= 1'b0;
    end else begin
      cpu_clk_en <= cpu_run;
      pll_power_en <= !src_slow;
      op_mode <= next_op_mode;
      irq_req <= osc_stable_flag && irq_mask;
    end
  end

  // Read data is loaded in the wait cycle, after any earlier write landed
  wire [31:0] rd_osc = 32'({osc_startup_count, 7'h00, main_osc_en});
  wire [31:0] rd_meas = 32'({freq_measure_done, measured_cycle_count});
  wire [31:0] rd_stat = 32'({op_mode, cpu_run, osc_stable_flag});
  wire [31:0] rd_clk = 32'({prog_clk_sel, 3'h0, usb_div2_en, 2'h0, sys_clk_source});
  logic [31:0] rd_mux;
  always_comb begin
    if (dp_addr == OFS_OSC_CTRL) rd_mux = rd_osc;
    else if (dp_addr == OFS_FREQ_MEASURE) rd_mux = rd_meas;
    else if (dp_addr == OFS_POWER_STATUS) rd_mux = rd_stat;
    else if (dp_addr == OFS_IRQ_MASK) rd_mux = 32'(irq_mask);
    else if (dp_addr == OFS_CLK_CTRL) rd_mux = rd_clk;
    else if (dp_addr == OFS_PERIPH_EN) rd_mux = 32'(periph_clk_en);
    else rd_mux = 32'h0000_0000;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) hrdata <= 32'h0000_0000;
    else if (acc_rd) hrdata <= rd_mux;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_start;
    wr_osc_on;
  endsequence
  sequence s_loaded;
    !osc_stable_flag && counting && (startup_left == $past(wr_count));
  endsequence
  sequence s_idle_req;
    wr_cpu && hwdata[IDLE_REQ_POS] && !wake_lvl;
  endsequence

  property p_off_clears;
    wr_osc_off |=> !main_osc_en && !osc_stable_flag && !counting;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("disable left flag set");

  property p_start_load;
    s_start |=> s_loaded;
  endproperty
  a_start_load: assert property (p_start_load) else $error("startup not loaded");

  property p_decrement;
    counting && slow_rise && startup_left != '0 && !acc_wr
      |=> startup_left == $past(startup_left) - 1'b1;
  endproperty
  a_decrement: assert property (p_decrement) else $error("countdown step wrong");

  property p_stable_zero;
    count_zero && !wr_osc |=> osc_stable_flag ##1 (irq_req == irq_mask);
  endproperty
  a_stable_zero: assert property (p_stable_zero) else $error("stable not set at zero");

  property p_irq;
    osc_stable_flag && irq_mask && !wr_mask |=> irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_meter_arm;
    meter_state == METER_ARM && slow_rise && osc_stable_flag
      |=> meter_state == METER_COUNT && measured_cycle_count == '0;
  endproperty
  a_meter_arm: assert property (p_meter_arm) else $error("meter did not start");

  property p_meter_done;
    meter_state == METER_COUNT && last_fall && osc_stable_flag |=> freq_measure_done;
  endproperty
  a_meter_done: assert property (p_meter_done) else $error("meter did not finish");

  property p_frozen;
    freq_measure_done ##1 freq_measure_done |-> $stable(measured_cycle_count);
  endproperty
  a_frozen: assert property (p_frozen) else $error("meter value moved after done");

  property p_wake;
    wake_lvl |=> ##1 cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("processor clock not restarted");

  property p_slow_pll_off;
    src_slow ##1 src_slow |-> !pll_power_en;
  endproperty
  a_slow_pll_off: assert property (p_slow_pll_off) else $error("PLL on in slow mode");

  property p_stable_needs_en;
    osc_stable_flag |-> main_osc_en;
  endproperty
  a_stable_needs_en: assert property (p_stable_needs_en) else $error("stable while off");

  property p_count_load;
    wr_osc |=> osc_startup_count == $past(wr_count);
  endproperty
  a_count_load: assert property (p_count_load) else $error("startup count not kept");

  property p_no_self_set;
    !counting && !osc_stable_flag |=> !osc_stable_flag;
  endproperty
  a_no_self_set: assert property (p_no_self_set) else $error("stable set without count");

  property p_meter_clear;
    meter_state == METER_ARM |=> measured_cycle_count == '0;
  endproperty
  a_meter_clear: assert property (p_meter_clear) else $error("meter not cleared");

  property p_meter_step;
    meter_state == METER_COUNT && main_rise
      |=> measured_cycle_count == $past(measured_cycle_count) + 1'b1;
  endproperty
  a_meter_step: assert property (p_meter_step) else $error("meter missed a main edge");

  property p_done_falls;
    freq_measure_done |-> fall_cnt == MEAS_SLOW_PERIODS;
  endproperty
  a_done_falls: assert property (p_done_falls) else $error("done at wrong fall count");

  property p_done_drop;
    !osc_stable_flag |=> !freq_measure_done;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("done kept without stable");

  property p_idle;
    s_idle_req |=> ##1 !cpu_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("processor clock not stopped");

  property p_normal;
    !src_slow && cpu_run |=> op_mode == MODE_NORMAL && cpu_clk_en;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode wrong");

  property p_standby;
    src_slow && !cpu_run |=> op_mode == MODE_STANDBY && !cpu_clk_en;
  endproperty
  a_standby: assert property (p_standby) else $error("standby mode wrong");

  property p_periph;
    wr_per |=> periph_clk_en == $past(hwdata[NUM_PERIPH-1:0]);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral gates not written");

  property p_clk_sel;
    wr_clk |=> prog_clk_sel == $past(hwdata[PROG_SEL_LSB +: 8])
      && usb_div2_en == $past(hwdata[USB_DIV2_POS]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock selects not written");
endmodule

// File: verification/main_osc_control_tb.sv
// Self-checking bench for the main oscillator control and frequency meter block
`timescale 1ns/100ps
module main_osc_control_tb;
  import osc_ctrl_pkg::*;
  logic ref_clk, reset_n, hwrite, hready, hreadyout, hresp, low_speed_clk, main_clk, wake_req;
  logic [1:0] htrans, sys_clk_source, op_mode;
  logic [31:0] haddr, hwdata, hrdata, rng;
  logic main_osc_en, pll_power_en, cpu_clk_en, usb_div2_en, irq_req;
  logic [29:0] periph_clk_en;
  logic [7:0] prog_clk_sel;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic rd_phase = 1'b0;
  int bad_count, num_checks, n, rdy_edges;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  main_osc_control DUT (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_speed_clk(low_speed_clk),
    .main_clk(main_clk), .wake_req(wake_req), .main_osc_en(main_osc_en),
    .pll_power_en(pll_power_en), .sys_clk_source(sys_clk_source), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .usb_div2_en(usb_div2_en), .prog_clk_sel(prog_clk_sel),
    .op_mode(op_mode), .irq_req(irq_req));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Shortened slow period (64 ref cycles) keeps the run small; it never stops
  initial begin
    low_speed_clk = 1'b0;
    forever #800 low_speed_clk = ~low_speed_clk;
  end
  // Crystal only swings while enabled; edges kept off the ref rising edges
  initial begin
    main_clk = 1'b0;
    #50;
    forever #100 main_clk = main_osc_en ? ~main_clk : 1'b0;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    bad_count++;
    $display("CHECK FAILED wait expected done seen timeout");
    print_verdict();
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    rdy_edges = k;
    if (hready !== 1'b1) timeout();
  endtask

  task automatic wait_hi(input bit cpu, input int lim);
    n = 0;
    while ((cpu ? cpu_clk_en : irq_req) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) timeout();
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    htrans <= 2'b00;
    if (w) hwdata <= d;
    wait_rdy();
    check("data wait", rdy_edges, w ? 32'h1 : 32'h2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, e, m);
  endtask

  // Read data is taken at the edge that ends the read data phase
  always @(posedge ref_clk) begin
    if (rd_phase && hreadyout === 1'b1 && exp_q.size() > 0) begin
      check("read data", hrdata & msk_q.pop_front(), exp_q.pop_front());
    end
    if (hready) rd_phase = reset_n && htrans[1] && !hwrite;
  end

  initial begin
    reset_n = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wake_req = 1'b0;
    rng = 32'd52755;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check("osc enable", main_osc_en, 1'b0);
    check("mode", op_mode, MODE_SLOW);
    check("pll power", pll_power_en, 1'b0);
    rd(OFS_POWER_STATUS, 32'ha, 32'hf);
    rd(OFS_OSC_CTRL, 32'h0, 32'hff01);
    wr(OFS_IRQ_MASK, 32'h1);
    // Start just after a synchronised slow rise, so an off-by-one count shows
    @(posedge low_speed_clk);
    repeat (8) @(posedge ref_clk);
    wr(OFS_OSC_CTRL, 32'h0000_0301);
    rd(OFS_POWER_STATUS, 32'h0, 32'h1);
    check("osc enable", main_osc_en, 1'b1);
    wait_hi(1'b0, 2000);
    check("startup", n >= 215 && n <= 285, 1'b1);
    rd(OFS_POWER_STATUS, 32'h1, 32'h1);
    rd(OFS_FREQ_MEASURE, 32'h0, 32'h1_0000);
    repeat (1300) @(posedge ref_clk);
    // Main is exactly 8x slow, so 15.5 slow periods hold 124 main rises
    rd(OFS_FREQ_MEASURE, 32'h1_007c, 32'h1_ffff);
    repeat (200) @(posedge ref_clk);
    rd(OFS_FREQ_MEASURE, 32'h1_007c, 32'h1_ffff);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq masked", irq_req, 1'b0);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_OSC_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq off", irq_req, 1'b0);
    check("osc enable", main_osc_en, 1'b0);
    rd(OFS_POWER_STATUS, 32'h0, 32'h1);
    rng = xs(rng);
    wr(OFS_OSC_CTRL, {rng[31:16], 8'hff, 7'h0, 1'b1});
    rd(OFS_OSC_CTRL, 32'hff01, 32'hff01);
    wr(OFS_OSC_CTRL, 32'h0000_0501);
    repeat (128) @(posedge ref_clk);
    wr(OFS_OSC_CTRL, 32'h0);
    repeat (600) @(posedge ref_clk);
    rd(OFS_POWER_STATUS, 32'h0, 32'h1);
    check("irq after abort", irq_req, 1'b0);
    rng = xs(rng);
    wr(OFS_PERIPH_EN, rng);
    rd(OFS_PERIPH_EN, rng, 32'h3fff_ffff);
    check("periph gates", periph_clk_en, rng[29:0]);
    wr(OFS_CLK_CTRL, {16'h0, rng[15:8], 3'h0, 1'b1, 2'h0, SRC_MAIN});
    repeat (2) @(posedge ref_clk);
    check("prog select", prog_clk_sel, rng[15:8]);
    check("usb div2", usb_div2_en, 1'b1);
    check("clock source", sys_clk_source, SRC_MAIN);
    check("pll power", pll_power_en, 1'b1);
    check("mode", op_mode, MODE_NORMAL);
    check("cpu clock", cpu_clk_en, 1'b1);
    wr(OFS_CPU_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("cpu clock", cpu_clk_en, 1'b0);
    check("periph gates", periph_clk_en, rng[29:0]);
    rd(OFS_POWER_STATUS, 32'h4, 32'hf);
    wake_req <= 1'b1;
    wait_hi(1'b1, 12);
    wake_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wr(OFS_CLK_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("mode", op_mode, MODE_SLOW);
    check("pll power", pll_power_en, 1'b0);
    wr(OFS_CPU_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("mode", op_mode, MODE_STANDBY);
    check("cpu clock", cpu_clk_en, 1'b0);
    wake_req <= 1'b1;
    wait_hi(1'b1, 12);
    wake_req <= 1'b0;
    wr(OFS_CLK_CTRL, 32'h0000_0002);
    rd(OFS_CLK_CTRL, 32'h2, 32'h3);
    check("clock source", sys_clk_source, SRC_PLL);
    check("pll power", pll_power_en, 1'b1);
    // Warm reset in mid-run with the oscillator enabled and the PLL selected
    wr(OFS_OSC_CTRL, 32'h0000_0301);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check("osc enable", main_osc_en, 1'b0);
    check("mode", op_mode, MODE_SLOW);
    check("clock source", sys_clk_source, SRC_LOW_SPEED);
    check("pll power", pll_power_en, 1'b0);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    rd(OFS_CPU_CTRL, 32'h0, 32'hffff_ffff);
    check("response", hresp, 1'b0);
    print_verdict();
  end
endmodule
